// ===== verilog/sltc_core.sv
// How it works
// R1: Panel drives only while the drive enable bit is one.
// R2: Sleep halt select one stops the module during processor sleep.
// R3: Voltage generator bit powers the internal bias generator up or down.
// R4: Source field: 00 system clock over 256, 01 Timer1, 1x RC.
// R5: Common field: 00 static, 01/10/11 two, three, four commons.
// R6: At most 32 segments, one fewer per extra common.
// R7: Prescale register holds four bits; upper four read zero.
// R8: Static, two and four common frame is source over 128 times (value+1).
// R9: Three common frame is source over 96 times (value+1).
// R10: Sixteen byte-wide pixel registers feed the waveform generator.
// R11: Data bit one drives pixel dark, zero drives it clear.
// R12: Reset clears control and prescale registers to zero.
// R13: A frame starts at the leading edge of the first common.
// R14: Frame flag sets once the last common's pixel data is fetched.
// R15: RC source is powered only while selected and drive is enabled.
// R16: Disabled drive holds counters idle; enable restarts at first common.
//
// Chosen here: the plain strobed port.
module sltc_core (
	// Clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_srst,
	// Register port
	input  wire logic [8:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rd_data,
	// Core and timing sources
	input  wire logic        i_sleep,
	input  wire logic        i_tmr1_clk,
	input  wire logic        i_rc_clk,
	// Panel side
	output logic      [3:0]  o_com,
	output logic      [31:0] o_seg,
	output logic             o_frame_start,
	output logic             o_bias_gen_on,
	output logic             o_rc_osc_enable,
	// Interrupt
	output logic             o_irq
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] phase_len(input logic [1:0] mux);
		case (mux)
			2'h0:    phase_len = sltc_pkg::PHASE_STATIC;
			2'h1:    phase_len = sltc_pkg::PHASE_TWO;
			2'h2:    phase_len = sltc_pkg::PHASE_THREE;
			default: phase_len = sltc_pkg::PHASE_FOUR;
		endcase
	endfunction

	// Segments above the usable count are forced clear.
	function automatic logic [31:0] seg_mask(input logic [1:0] mux);
		seg_mask = {32{1'b1}} >> mux;
	endfunction

	sltc_pkg::sltc_state_t st;
	sltc_pkg::sltc_state_t next_st;
	sltc_pkg::sltc_bus_t   bus;
	logic [31:0]           com_row [sltc_pkg::NUM_COM];

	assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

	// Each common owns four consecutive pixel registers.
	genvar g;
	generate
		for (g = 0; g < sltc_pkg::NUM_COM; g++) begin : g_row
			assign com_row[g] = {st.pix[4*g+3], st.pix[4*g+2], st.pix[4*g+1],
				st.pix[4*g]}; // see R10
		end
	endgenerate

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic [1:0] src;
	logic [1:0] mux;
	logic       tick;
	logic       en;
	logic       halt;
	logic       wrap;
	logic [1:0] new_idx;
	logic       fetch;

	always_comb begin
		next_st = st;
		src = st.ctrl[sltc_pkg::SRC_HI:sltc_pkg::SRC_LO];
		mux = st.ctrl[sltc_pkg::MUX_HI:sltc_pkg::MUX_LO];
		en = st.ctrl[sltc_pkg::BIT_EN];
		wrap = 1'b0;
		new_idx = st.com_idx;
		fetch = 1'b0;
		next_st.frame_start = 1'b0;

		// Pin sources are synchronised before any edge detection.
		next_st.t1_s = {st.t1_s[1:0], i_tmr1_clk};
		next_st.rc_s = {st.rc_s[1:0], i_rc_clk};
		next_st.div = st.div + 8'h01;
		if (src == sltc_pkg::SRC_SYS) begin
			tick = (st.div == sltc_pkg::SYS_DIV_LAST); // see R4
		end else if (src == sltc_pkg::SRC_TMR1) begin
			tick = st.t1_s[1] & ~st.t1_s[2]; // see R4
		end else begin
			tick = st.rc_s[1] & ~st.rc_s[2]; // see R4
		end

		// The system clock stops in sleep, so that source halts as well.
		halt = i_sleep & (st.ctrl[sltc_pkg::BIT_SLP] | (src == sltc_pkg::SRC_SYS)); // see R2

		if (!en) begin
			next_st.mode = sltc_pkg::SLTC_OFF; // see R1
			next_st.pre = '0; // see R16
			next_st.ph = '0;
			next_st.com_idx = '0;
		end else if (halt) begin
			next_st.mode = sltc_pkg::SLTC_HOLD; // see R2
		end else if (st.mode != sltc_pkg::SLTC_RUN) begin
			next_st.mode = sltc_pkg::SLTC_RUN;
			fetch = 1'b1; // see R16
		end else if (tick) begin
			if (st.pre >= st.ps) begin
				next_st.pre = '0;
				if (st.ph >= phase_len(mux) - 8'h01) begin // see R8 see R9
					next_st.ph = '0;
					wrap = 1'b1;
				end else begin
					next_st.ph = st.ph + 8'h01;
				end
			end else begin
				next_st.pre = st.pre + 4'h1;
			end
		end

		if (wrap) begin
			new_idx = (st.com_idx >= mux) ? 2'h0 : st.com_idx + 2'h1; // see R5
			fetch = 1'b1;
		end
		if (fetch) begin
			next_st.com_idx = new_idx;
			next_st.seg = com_row[new_idx] & seg_mask(mux); // see R11 see R6
			next_st.frame_start = (new_idx == 2'h0); // see R13
		end

		if (next_st.mode == sltc_pkg::SLTC_RUN) begin
			next_st.com = 4'h1 << next_st.com_idx; // see R5
		end else begin
			next_st.com = '0;
			next_st.seg = '0; // see R1
		end

		// Register port.
		next_st.rd_data = sltc_pkg::RD_UNMAPPED;
		if (bus.wr) begin
			if (bus.addr == sltc_pkg::ADDR_CTRL) begin
				next_st.ctrl = bus.wdata & sltc_pkg::CTRL_WMASK;
			end else if (bus.addr == sltc_pkg::ADDR_PS) begin
				next_st.ps = bus.wdata[3:0]; // see R7
			end else if (bus.addr >= sltc_pkg::ADDR_PIX_LO && bus.addr <= sltc_pkg::ADDR_PIX_HI) begin
				next_st.pix[bus.addr[3:0]] = bus.wdata; // see R10
			end else if (bus.addr == sltc_pkg::ADDR_MASK) begin
				next_st.mask = bus.wdata[sltc_pkg::STAT_FRAME];
			end
		end
		if (bus.rd) begin
			if (bus.addr == sltc_pkg::ADDR_CTRL) begin
				next_st.rd_data = st.ctrl;
			end else if (bus.addr == sltc_pkg::ADDR_PS) begin
				next_st.rd_data = {4'h0, st.ps}; // see R7
			end else if (bus.addr >= sltc_pkg::ADDR_PIX_LO && bus.addr <= sltc_pkg::ADDR_PIX_HI) begin
				next_st.rd_data = st.pix[bus.addr[3:0]];
			end else if (bus.addr == sltc_pkg::ADDR_STAT) begin
				next_st.rd_data = {7'h00, st.stat};
				next_st.stat = 1'b0;
			end else if (bus.addr == sltc_pkg::ADDR_MASK) begin
				next_st.rd_data = {7'h00, st.mask};
			end
		end
		// A fetch of the last common's data sets the flag; set beats the read clear.
		if (fetch && new_idx == mux) begin
			next_st.stat = 1'b1; // see R14
		end

		next_st.irq = next_st.stat & next_st.mask;
		next_st.bias_on = next_st.ctrl[sltc_pkg::BIT_BIAS_GENERATOR_ON]; // see R3
		next_st.rc_en = next_st.ctrl[sltc_pkg::BIT_EN] &
			next_st.ctrl[sltc_pkg::SRC_HI]; // see R15
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			st <= '0; // see R12
			st.ctrl <= sltc_pkg::CTRL_RST;
			st.ps <= sltc_pkg::PS_RST;
			st.mode <= sltc_pkg::SLTC_OFF;
		end else begin
			st <= next_st;
		end
	end

	assign o_rd_data = st.rd_data;
	assign o_com = st.com;
	assign o_seg = st.seg;
	assign o_frame_start = st.frame_start;
	assign o_bias_gen_on = st.bias_on;
	assign o_rc_osc_enable = st.rc_en;
	assign o_irq = st.irq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_drive_off: assert property (@(posedge i_sys_clk) disable iff (i_srst) // see R1
		!st.ctrl[sltc_pkg::BIT_EN] |=> (o_com == 4'h0) && (o_seg == 32'h0))
		else $error("panel driven while drive disabled");

	chk_sleep_halt: assert property (@(posedge i_sys_clk) disable iff (i_srst) // see R2
		(i_sleep && st.ctrl[sltc_pkg::BIT_SLP]) |=> (o_com == 4'h0))
		else $error("commons driven during halting sleep");

	chk_bias_write: assert property (@(posedge i_sys_clk) disable iff (i_srst) // see R3
		(i_wr && i_addr == sltc_pkg::ADDR_CTRL) |=> (o_bias_gen_on == $past(i_wdata[4])))
		else $error("bias generator does not follow control write");

	chk_ps_upper: assert property (@(posedge i_sys_clk) disable iff (i_srst) // see R7
		(i_rd && i_addr == sltc_pkg::ADDR_PS) |=> (o_rd_data[7:4] == 4'h0))
		else $error("prescale upper bits not zero");

	chk_rc_power: assert property (@(posedge i_sys_clk) disable iff (i_srst) // see R15
		o_rc_osc_enable |-> (st.ctrl[7] && st.ctrl[3]))
		else $error("RC source powered while unused");

	chk_seg_limit: assert property (@(posedge i_sys_clk) disable iff (i_srst) // see R6
		(o_seg & ~seg_mask(st.ctrl[1:0])) == 32'h0 || $changed(st.ctrl[1:0]))
		else $error("segment beyond usable count driven");

	chk_frame_first_common_line: assert property (@(posedge i_sys_clk) disable iff (i_srst) // see R13
		o_frame_start |-> (o_com == 4'h1))
		else $error("frame start not on first common");

	chk_reset_clear: assert property (@(posedge i_sys_clk) // see R12
		$past(i_srst) |-> (st.ctrl == 8'h00 && st.ps == 4'h0 && o_com == 4'h0))
		else $error("registers not cleared by reset");

	chk_phase_bound: assert property (@(posedge i_sys_clk) disable iff (i_srst) // see R8
		st.ph < phase_len(st.ctrl[1:0]) || $changed(st.ctrl[1:0]))
		else $error("phase counter beyond phase length");

	chk_enable_start: assert property (@(posedge i_sys_clk) disable iff (i_srst) // see R16
		(st.mode == sltc_pkg::SLTC_OFF && st.ctrl[7] && !i_sleep) |=> o_frame_start)
		else $error("enable does not restart at first common");

endmodule // sltc_core

// ===== verilog/sltc_pkg.sv
package sltc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int          ADDR_W        = 9;
	localparam logic [8:0]  ADDR_PS       = 9'h10E;
	localparam logic [8:0]  ADDR_CTRL     = 9'h10F;
	localparam logic [8:0]  ADDR_PIX_LO   = 9'h110;
	localparam logic [8:0]  ADDR_PIX_HI   = 9'h11F;
	localparam logic [8:0]  ADDR_STAT     = 9'h120;
	localparam logic [8:0]  ADDR_MASK     = 9'h121;
	localparam logic [7:0]  CTRL_RST      = 8'h00;
	localparam logic [3:0]  PS_RST        = 4'h0;
	localparam logic [7:0]  CTRL_WMASK    = 8'hDF;
	localparam logic [7:0]  RD_UNMAPPED   = 8'h00;

	// ----------------------------------------------------------------
	// Control field positions
	// ----------------------------------------------------------------
	localparam int BIT_EN    = 7;
	localparam int BIT_SLP   = 6;
	localparam int BIT_BIAS_GENERATOR_ON  = 4;
	localparam int SRC_HI    = 3;
	localparam int SRC_LO    = 2;
	localparam int MUX_HI    = 1;
	localparam int MUX_LO    = 0;

	// ----------------------------------------------------------------
	// Timing source, multiplex and frame constants
	// ----------------------------------------------------------------
	localparam logic [1:0]  SRC_SYS       = 2'h0;
	localparam logic [1:0]  SRC_TMR1      = 2'h1;
	localparam logic [7:0]  SYS_DIV_LAST  = 8'hFF;
	localparam logic [7:0]  PHASE_STATIC  = 8'h80;
	localparam logic [7:0]  PHASE_TWO     = 8'h40;
	localparam logic [7:0]  PHASE_THREE   = 8'h20;
	localparam logic [7:0]  PHASE_FOUR    = 8'h20;
	localparam int          NUM_SEG       = 32;
	localparam int          NUM_COM       = 4;
	localparam int          NUM_PIX_REG   = 16;
	localparam int          STAT_FRAME    = 0;

	typedef enum logic [1:0] {
		SLTC_OFF  = 2'b00,
		SLTC_RUN  = 2'b01,
		SLTC_HOLD = 2'b10
	} sltc_mode_t;

	typedef struct packed {
		logic [8:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} sltc_bus_t;

	typedef struct packed {
		sltc_mode_t                 mode;
		logic [7:0]                 ctrl;
		logic [3:0]                 ps;
		logic [15:0][7:0]           pix;
		logic                       stat;
		logic                       mask;
		logic [2:0]                 t1_s;
		logic [2:0]                 rc_s;
		logic [7:0]                 div;
		logic [3:0]                 pre;
		logic [7:0]                 ph;
		logic [1:0]                 com_idx;
		logic [3:0]                 com;
		logic [31:0]                seg;
		logic                       frame_start;
		logic                       irq;
		logic                       rc_en;
		logic                       bias_on;
		logic [7:0]                 rd_data;
	} sltc_state_t;

endpackage

// ===== verif/sltc_panel_model.sv
module sltc_panel_model (
	// Clock and panel lines
	input  wire logic             i_sys_clk,
	input  wire logic [3:0]       i_com,
	input  wire logic [31:0]      i_seg,
	input  wire logic             i_frame_start,
	// Internal oscillator
	input  wire logic             i_rc_en,
	output logic                  o_rc_clk,
	// Observations
	output logic [15:0]           o_frame_len,
	output logic [3:0][31:0]      o_seen
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] cnt;

	// The oscillator stands still while powered down; the small offset keeps its
	// edges away from the system clock edges.
	initial begin
		o_rc_clk = 1'b0;
		forever begin
			if (i_rc_en) begin
				#200 o_rc_clk = ~o_rc_clk;
			end else begin
				o_rc_clk = 1'b0;
				@(posedge i_rc_en);
				#7;
			end
		end
	end

	always @(posedge i_sys_clk) begin
		cnt <= i_frame_start ? 16'h0001 : cnt + 16'h0001;
		if (i_frame_start) begin
			o_frame_len <= cnt;
		end
		for (int c = 0; c < 4; c++) begin
			if (i_com[c]) begin
				o_seen[c] <= i_seg;
			end
		end
	end
endmodule // sltc_panel_model

// ===== verif/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic             clk, srst, wr, rd, sleep, tmr1, fs, bias, rcen, rcclk, irq;
	logic [8:0]       addr;
	logic [7:0]       wdata, rdata, v;
	logic [3:0]       com;
	logic [31:0]      seg;
	logic [15:0]      flen;
	logic [3:0][31:0] seen;
	logic [15:0][7:0] pix;
	logic [8:0]       ra [5];
	int               n_fail = 0;
	int               check_count = 0;

	sltc_core sltc_core_i (.i_sys_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rd_data(rdata), .i_sleep(sleep), .i_tmr1_clk(tmr1),
		.i_rc_clk(rcclk), .o_com(com), .o_seg(seg), .o_frame_start(fs),
		.o_bias_gen_on(bias), .o_rc_osc_enable(rcen), .o_irq(irq));
	sltc_panel_model sltc_panel_model_i (.i_sys_clk(clk), .i_com(com), .i_seg(seg),
		.i_frame_start(fs), .i_rc_en(rcen), .o_rc_clk(rcclk), .o_frame_len(flen),
		.o_seen(seen));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Timer1 ticks every six system cycles, on a falling system edge, never on a rising one.
	initial begin
		tmr1 = 1'b0;
		forever #150 tmr1 = ~tmr1;
	end

	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [8:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask

	task automatic wait_fs();
		int k;
		for (k = 0; k < 6000; k++) begin
			@(negedge clk);
			if (fs === 1'b1) break;
		end
		if (k == 6000) begin
			n_fail++;
			final_report();
		end
	endtask

	function automatic logic [31:0] exp_seg(int c, int mux);
		return {pix[4*c+3], pix[4*c+2], pix[4*c+1], pix[4*c]} & (32'hFFFF_FFFF >> mux);
	endfunction

	task automatic run_mode(input int src, input int mux, input int lp, input int per);
		logic [7:0] c;
		c = 8'(8'hA0 | (($urandom % 2) << 4) | (src << 2) | mux);
		wr_reg(sltc_pkg::ADDR_PS, 8'(8'hA0 | lp));
		rd_reg(sltc_pkg::ADDR_PS, v);
		check("prescale", v, 32'(lp));
		wr_reg(sltc_pkg::ADDR_CTRL, c);
		rd_reg(sltc_pkg::ADDR_CTRL, v);
		check("control", v, c & 8'hDF);
		check("bias", bias, c[4]);
		check("rc enable", rcen, src >= 2);
		wait_fs();
		check("first common", com, 4'h1);
		wait_fs();
		wait_fs();
		check("frame", flen, per * (lp + 1) * (mux == 2 ? 96 : 128));
		for (int i = 0; i <= mux; i++) begin
			check("segments", seen[i], exp_seg(i, mux));
		end
		wr_reg(sltc_pkg::ADDR_CTRL, 8'h00);
		repeat (3) @(negedge clk);
		check("drive off", com, 4'h0);
		$display("source %0d mux %0d done", src, mux);
	endtask

	initial begin
		{srst, wr, rd, sleep, addr, wdata} = {4'h8, 9'h000, 8'h00};
		v = 8'($urandom(32'hB6B8));
		ra = '{sltc_pkg::ADDR_PS, sltc_pkg::ADDR_CTRL, sltc_pkg::ADDR_STAT,
			sltc_pkg::ADDR_MASK, 9'h000};
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		wr_reg(9'h000, 8'h5A);
		for (int i = 0; i < 5; i++) begin
			rd_reg(ra[i], v);
			check("reset value", v, 8'h00);
		end
		for (int i = 0; i < 16; i++) begin
			pix[i] = 8'($urandom) | ((i % 4 == 3) ? 8'h80 : 8'h00);
			wr_reg(sltc_pkg::ADDR_PIX_LO + 9'(i), pix[i]);
			rd_reg(sltc_pkg::ADDR_PIX_LO + 9'(i), v);
			check("pixel", v, pix[i]);
		end
		$display("registers done");
		for (int m = 0; m < 4; m++) begin
			run_mode(1, m, $urandom % 3, 6);
		end
		run_mode(2, 1, 0, 8);
		run_mode(3, 2, 1, 8);
		wr_reg(sltc_pkg::ADDR_MASK, 8'h01);
		wr_reg(sltc_pkg::ADDR_CTRL, 8'h87);
		wait_fs();
		wait_fs();
		rd_reg(sltc_pkg::ADDR_STAT, v);
		repeat (2) @(negedge clk);
		check("status", v, 8'h01);
		check("irq cleared", irq, 1'b0);
		wait_fs();
		check("irq set", irq, 1'b1);
		wr_reg(sltc_pkg::ADDR_MASK, 8'h00);
		repeat (2) @(negedge clk);
		check("irq masked", irq, 1'b0);
		@(posedge clk);
		sleep <= 1'b1;
		wait_fs();
		check("sleep display", com, 4'h1);
		wr_reg(sltc_pkg::ADDR_CTRL, 8'hC7);
		repeat (3) @(negedge clk);
		check("sleep halt", com, 4'h0);
		@(posedge clk);
		sleep <= 1'b0;
		wait_fs();
		wr_reg(sltc_pkg::ADDR_CTRL, 8'h80);
		repeat (3) @(negedge clk);
		check("system source run", com, 4'h1);
		@(posedge clk);
		sleep <= 1'b1;
		repeat (3) @(negedge clk);
		check("system source sleep", com, 4'h0);
		@(posedge clk);
		sleep <= 1'b0;
		$display("interrupt and sleep done");
		final_report();
	end
endmodule // tb
